// *** sim/bus_area_control_register_decode_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module bus_area_control_register_decode_tb;
    import bus_area_pkg::*;
    localparam logic [17:0] ctl = bus_area_control_addr;
    localparam logic [17:0] wab = word_area_boundary_addr;
    localparam logic [17:0] sab = slow_area_boundary_addr;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [2:0] mode = 3'h5;
    logic [17:0] awaddr = 18'h0, araddr = 18'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, narrow, slow, redir, sel, ext, hit;
    logic [1:0] bresp, rresp;
    logic [19:0] tgt = 20'h0, addr;
    logic [19:0] pw [5] = '{20'h0fe80, 20'h0fe90, 20'h0fe94, 20'h0fe98, 20'h0fe9c};
    int mismatches = 0, cmp_count = 0, cyc = 0;
    cpu_access_model cpu_access_model_i (.aclk(aclk), .target(tgt), .access_addr(addr),
        .access_external(ext), .access_port_hit(hit));
    bus_area_control_regs bus_area_control_regs_i (.aclk(aclk), .aresetn(aresetn),
        .mode(mode), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .access_addr(addr), .access_external(ext),
        .access_port_hit(hit), .access_narrow(narrow), .access_slow(slow),
        .access_redirected(redir), .onchip_port_select(sel));
    initial begin
        forever #4 aclk = ~aclk;
    end
    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic rst(input logic [2:0] m);
        @(posedge aclk);
        mode <= m;
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask : rst
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        `CHK(bresp, er)
    endtask : wr
    task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        `CHK(rdata, ed)
        `CHK(rresp, er)
    endtask : rd
    // checks {redirected, narrow, slow} under a mask
    task automatic st(input logic [19:0] a, input logic [2:0] e, input logic [2:0] m);
        @(posedge aclk);
        tgt <= a;
        repeat (2) @(posedge aclk);
        #1;
        `CHK({redir, narrow, slow} & m, e)
    endtask : st
    initial begin
        rst(3'h5);
        rd(ctl, 32'h3f, axi_okay);
        rd(wab, 32'hff, axi_okay);
        rd(sab, 32'h0e, axi_okay);
        st(20'h00100, 3'h3, 3'h7);
        wr(ctl, 32'h80, axi_okay);
        st(20'h00100, 3'h0, 3'h7);
        st(20'h20000, 3'h1, 3'h7);
        rd(ctl, 32'ha0, axi_okay);
        foreach (pw[i]) begin
            st(pw[i], 3'h7, 3'h7);
            `CHK(sel, 1'h0)
        end
        wr(sab, 32'h40, axi_okay);
        wr(wab, 32'h3f, axi_okay);
        wr(ctl, 32'hdf, axi_okay);
        rd(ctl, 32'hff, axi_okay);
        rd(sab, 32'h40, axi_okay);
        rd(wab, 32'h3f, axi_okay);
        st(20'h00100, 3'h1, 3'h7);
        st(20'h20000, 3'h0, 3'h7);
        st(20'h3f000, 3'h0, 3'h7);
        st(20'h40000, 3'h3, 3'h7);
        st(20'h0fe80, 3'h0, 3'h4);
        `CHK(sel, 1'h1)
        st(20'h0fe9c, 3'h0, 3'h4);
        `CHK(sel, 1'h0)
        wr(18'h00000, 32'h0, axi_slverr);
        rd(18'h00000, 32'h0, axi_slverr);
        rst(3'h1);
        rd(ctl, 32'hbf, axi_okay);
        rd(sab, 32'hee, axi_okay);
        st(20'h0ef00, 3'h1, 3'h7);
        st(20'h0ed00, 3'h0, 3'h7);
        wr(ctl, 32'h0, axi_okay);
        rd(ctl, 32'ha0, axi_okay);
        rst(3'h7);
        wr(ctl, 32'h0, axi_okay);
        rd(ctl, 32'hbf, axi_okay);
        st(20'h0fe80, 3'h0, 3'h4);
        `CHK(sel, 1'h1)
        wr(ctl, 32'h40, axi_okay);
        rd(ctl, 32'hff, axi_okay);
        st(20'h00100, 3'h0, 3'h7);
        rst(3'h6);
        rd(ctl, 32'h3f, axi_okay);
        rd(sab, 32'hee, axi_okay);
        rd(wab, 32'hff, axi_okay);
        rst(3'h2);
        st(20'h00100, 3'h3, 3'h7);
        conclude();
    end
endmodule : bus_area_control_register_decode_tb

// *** sim/bus_area_control_regs_assertions.sv ***
`timescale 1ns/1ps
module bus_area_control_checker
    import bus_area_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] mode,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic access_port_hit,
    input wire logic access_narrow,
    input wire logic access_slow,
    input wire logic access_redirected,
    input wire logic onchip_port_select
);
    logic [17:0] rd_a;
    // address of the read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_a <= 18'h00000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_a <= s_axi_araddr;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_ctl;
        s_axi_rvalid && rd_a[17:2] == bus_area_control_index;
    endsequence
    a_read_answer: assert property (
        ar_take |=> s_axi_rvalid) else $error("read not answered");
    a_rvalid_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    a_bvalid_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_aw_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready) else $error("awready during response");
    a_unmapped_err: assert property (
        s_axi_rvalid && rd_a[17:2] != bus_area_control_index
        && rd_a[17:2] != word_area_boundary_index && rd_a[17:2] != slow_area_boundary_index
        |-> s_axi_rresp == axi_slverr && s_axi_rdata == 32'h0) else $error("unmapped read");
    a_reserved_one: assert property (
        rd_ctl |-> s_axi_rdata[reserved_one_bit]) else $error("reserved bit low");
    a_enable_kept: assert property (
        rd_ctl ##0 (mode != 3'h5 && mode != 3'h6) |-> s_axi_rdata[boundary_decode_enable_bit])
        else $error("enable bit cleared");
    a_redir_slow: assert property (
        access_redirected |-> access_narrow && access_slow) else $error("redirect not slow");
    a_select_gate: assert property (
        onchip_port_select |-> access_port_hit && !access_redirected)
        else $error("port select wrong");
    a_mode7_ports: assert property (
        (mode == 3'h7) [*3] |-> !access_redirected) else $error("redirect in mode 7");
endmodule : bus_area_control_checker
bind bus_area_control_regs bus_area_control_checker bus_area_control_checker_i (
    .aclk(aclk), .aresetn(aresetn), .mode(mode), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .access_port_hit(access_port_hit), .access_narrow(access_narrow),
    .access_slow(access_slow), .access_redirected(access_redirected),
    .onchip_port_select(onchip_port_select));

// *** sim/cpu_access_model.sv ***
`timescale 1ns/1ps
module cpu_access_model (
    input wire logic aclk,
    input wire logic [19:0] target,
    output logic [19:0] access_addr,
    output logic access_external,
    output logic access_port_hit
);
    // issues one bus address per cycle, flags port windows
    always_ff @(posedge aclk) begin
        access_addr <= target;
        access_port_hit <= target inside {[20'h0fe80:20'h0fe83], [20'h0fe90:20'h0fe9b]};
        access_external <= target < 20'h0fe80 || target > 20'h0ffff;
    end
endmodule : cpu_access_model

// *** src/access_steer.sv ***
`timescale 1ns/1ps
module access_steer
    import bus_area_pkg::*;
(
    access_steer_if.steer st
);
    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo,
        input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic redir;
    logic ext;
    logic [7:0] page;
    logic page_zero;

    always_comb begin
        redir = 1'b0;
        if (!st.control[ports_nine_a_enable_bit] && in_range(st.addr, ports_nine_a_lo,
            ports_nine_a_hi)) begin
            redir = 1'b1;
        end
        if (!st.control[ports_b_c_enable_bit] && in_range(st.addr, ports_b_c_lo,
            ports_b_c_hi)) begin
            redir = 1'b1;
        end
        if (!st.control[ports_one_two_enable_bit] && in_range(st.addr, ports_one_two_lo,
            ports_one_two_hi)) begin
            redir = 1'b1;
        end
        if (!st.control[pullup_ctrl_reg_enable_bit] && in_range(st.addr, pullup_ctrl_lo,
            pullup_ctrl_hi)) begin
            redir = 1'b1;
        end
        if (!st.control[external_port_window_disable_bit] && in_range(st.addr, ext_port_lo,
            ext_port_hi)) begin
            redir = 1'b1;
        end
    end

    assign ext = st.is_external || redir;
    assign page = st.max_mode ? st.addr[19:12] : st.addr[15:8];
    assign page_zero = st.max_mode ? (st.addr[19:16] == 4'h0) : 1'b1;
    assign st.redirected = redir;

    always_comb begin
        st.narrow_bus = 1'b0;
        st.slow_cycle = 1'b0;
        if (redir) begin
            st.narrow_bus = 1'b1;
            st.slow_cycle = 1'b1;
        end else if (ext && st.mode != 3'd7) begin
            if (!st.control[boundary_decode_enable_bit]) begin
                st.narrow_bus = 1'b1;
                st.slow_cycle = 1'b1;
            end else begin
                st.narrow_bus = (page > st.word_bound) || (st.mode == 3'd2);
                st.slow_cycle = (page >= st.slow_bound) || (st.mode == 3'd2);
                if (st.control[page_zero_slow_cycle_bit] && page_zero) begin
                    st.slow_cycle = 1'b1;
                end
            end
        end
    end
endmodule : access_steer

// *** src/access_steer_if.sv ***
`timescale 1ns/1ps
interface access_steer_if;
    logic [7:0] control;
    logic [7:0] word_bound;
    logic [7:0] slow_bound;
    logic [2:0] mode;
    logic [19:0] addr;
    logic is_external;
    logic max_mode;
    logic onchip_port_hit;
    logic narrow_bus;
    logic slow_cycle;
    logic redirected;
    modport regs (output control, word_bound, slow_bound, mode, addr, is_external, max_mode,
        onchip_port_hit, input narrow_bus, slow_cycle, redirected);
    modport steer (input control, word_bound, slow_bound, mode, addr, is_external, max_mode,
        onchip_port_hit, output narrow_bus, slow_cycle, redirected);
endinterface : access_steer_if

// *** src/bus_area_control_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - enable set: external width and cycle follow the two boundary registers, except mode 2 (always byte slow) and mode 7 (never).
// - enable clear: every external access is slow, byte wide, upper lanes.
// - enable resets 0 in modes 5, 6; else resets 1, cannot clear.
// - page-zero bit forces slow cycles for external page 0 addresses.
// - page-zero bit resets 0 and means nothing in mode 7.
// - bit 5 reads 1 always, writes ignored.
// - ports 9/a enable clear sends their addresses to external byte slow area.
// - ports b/c enable clear sends their addresses to external byte slow area.
// - ports 1/2 enable clear sends their addresses to external byte slow area.
// - pull-up enable clear sends pull-up addresses to external byte slow area.
// - expanded-port bit clear opens external port window; reset value 1.
// - in mode 7 the five port enable bits cannot be cleared.
// - port and pull-up enable bits reset to 1.
// - above word boundary byte wide; at or above slow boundary three-state.
// - new settings act on the bus cycle right after the write.
// - control register sits at index fedf (byte address 3fb7c), always readable and writable.
module bus_area_control_regs
    import bus_area_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] mode,
    input wire logic [17:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [17:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [19:0] access_addr,
    input wire logic access_external,
    input wire logic access_port_hit,
    output logic access_narrow,
    output logic access_slow,
    output logic access_redirected,
    output logic onchip_port_select
);
    logic [7:0] bus_area_control;
    logic [7:0] word_area_boundary;
    logic [7:0] slow_area_boundary;
    logic aw_held;
    logic w_held;
    logic [17:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [7:0] next_control;
    logic reset_seen;
    logic [2:0] mode_sync1;
    logic [2:0] mode_sync2;
    logic boot_enable;

    function automatic logic max_of(input logic [2:0] m);
        max_of = (m == 3'd3) || (m == 3'd4) || (m == 3'd5);
    endfunction : max_of

    function automatic logic mapped(input logic [17:0] a);
        mapped = (a[17:2] == bus_area_control_index) || (a[17:2] == word_area_boundary_index)
            || (a[17:2] == slow_area_boundary_index);
    endfunction : mapped

    function automatic logic [7:0] lane(input logic [31:0] d, input logic [1:0] idx);
        lane = d[8*idx +: 8];
    endfunction : lane

    // mode pins come from outside
    always_ff @(posedge aclk) begin
        mode_sync1 <= mode;
        mode_sync2 <= mode_sync1;
    end

    assign boot_enable = !((mode_sync2 == 3'd5) || (mode_sync2 == 3'd6));

    // write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 18'h00000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= axi_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (mapped(aw_addr)) begin
                s_axi_bresp <= axi_okay;
            end else begin
                s_axi_bresp <= axi_slverr;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        next_control = bus_area_control;
        if (w_strb[0]) begin
            next_control = lane(w_data, 2'd0);
        end
        next_control[reserved_one_bit] = 1'b1;
        if (boot_enable) begin
            next_control[boundary_decode_enable_bit] = 1'b1;
        end
        if (mode_sync2 == 3'd7) begin
            next_control = next_control | port_enable_mask;
        end
    end

    // first cycle after reset loads mode dependent values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_area_control <= bus_area_control_rst_on;
        end else if (!reset_seen) begin
            bus_area_control <= boot_enable ? bus_area_control_rst_on
                : bus_area_control_rst_off;
        end else if (do_write && aw_addr[17:2] == bus_area_control_index) begin
            bus_area_control <= next_control;
        end
    end

    // boundary registers, one word each, lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_area_boundary <= word_area_boundary_rst;
            slow_area_boundary <= slow_area_boundary_rst;
        end else if (!reset_seen) begin
            slow_area_boundary <= max_of(mode_sync2) ? slow_area_boundary_rst_max
                : slow_area_boundary_rst;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr[17:2] == word_area_boundary_index) begin
                word_area_boundary <= lane(w_data, 2'd0);
            end
            if (aw_addr[17:2] == slow_area_boundary_index) begin
                slow_area_boundary <= lane(w_data, 2'd0);
            end
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= axi_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= axi_okay;
            if (s_axi_araddr[17:2] == bus_area_control_index) begin
                s_axi_rdata <= {24'h000000, bus_area_control};
            end else if (s_axi_araddr[17:2] == word_area_boundary_index) begin
                s_axi_rdata <= {24'h000000, word_area_boundary};
            end else if (s_axi_araddr[17:2] == slow_area_boundary_index) begin
                s_axi_rdata <= {24'h000000, slow_area_boundary};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= axi_slverr;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    access_steer_if st_if ();
    assign st_if.control = bus_area_control;
    assign st_if.word_bound = word_area_boundary;
    assign st_if.slow_bound = slow_area_boundary;
    assign st_if.mode = mode_sync2;
    assign st_if.addr = access_addr;
    assign st_if.is_external = access_external;
    assign st_if.max_mode = max_of(mode_sync2);
    assign st_if.onchip_port_hit = access_port_hit;

    access_steer access_steer_i (
        .st(st_if.steer)
    );

    assign access_narrow = st_if.narrow_bus;
    assign access_slow = st_if.slow_cycle;
    assign access_redirected = st_if.redirected;
    assign onchip_port_select = access_port_hit && !st_if.redirected;
endmodule : bus_area_control_regs

// *** src/bus_area_pkg.sv ***
package bus_area_pkg;
    // register indices; axi4-lite byte address is four times the index
    localparam logic [15:0] bus_area_control_index = 16'hfedf;
    localparam logic [15:0] word_area_boundary_index = 16'hff16;
    localparam logic [15:0] slow_area_boundary_index = 16'hff17;
    localparam logic [17:0] bus_area_control_addr = {bus_area_control_index, 2'b00};
    localparam logic [17:0] word_area_boundary_addr = {word_area_boundary_index, 2'b00};
    localparam logic [17:0] slow_area_boundary_addr = {slow_area_boundary_index, 2'b00};
    // bus_area_control field positions
    localparam int boundary_decode_enable_bit = 7;
    localparam int page_zero_slow_cycle_bit = 6;
    localparam int reserved_one_bit = 5;
    localparam int ports_nine_a_enable_bit = 4;
    localparam int external_port_window_disable_bit = 3;
    localparam int pullup_ctrl_reg_enable_bit = 2;
    localparam int ports_b_c_enable_bit = 1;
    localparam int ports_one_two_enable_bit = 0;
    // reset values
    localparam logic [7:0] bus_area_control_rst_on = 8'hbf;
    localparam logic [7:0] bus_area_control_rst_off = 8'h3f;
    localparam logic [7:0] word_area_boundary_rst = 8'hff;
    localparam logic [7:0] slow_area_boundary_rst = 8'hee;
    localparam logic [7:0] slow_area_boundary_rst_max = 8'h0e;
    // mask of port enable bits that mode 7 keeps set
    localparam logic [7:0] port_enable_mask = 8'h1f;
    // redirected port windows, 20-bit addresses
    localparam logic [19:0] ports_one_two_lo = 20'h0fe80;
    localparam logic [19:0] ports_one_two_hi = 20'h0fe83;
    localparam logic [19:0] ports_nine_a_lo = 20'h0fe90;
    localparam logic [19:0] ports_nine_a_hi = 20'h0fe93;
    localparam logic [19:0] ports_b_c_lo = 20'h0fe94;
    localparam logic [19:0] ports_b_c_hi = 20'h0fe97;
    localparam logic [19:0] pullup_ctrl_lo = 20'h0fe98;
    localparam logic [19:0] pullup_ctrl_hi = 20'h0fe9b;
    localparam logic [19:0] ext_port_lo = 20'h0fe9c;
    localparam logic [19:0] ext_port_hi = 20'h0fe9f;
    localparam logic [1:0] axi_okay = 2'b00;
    localparam logic [1:0] axi_slverr = 2'b10;

    typedef enum logic [2:0] {
        wr_idle = 3'b001,
        wr_resp = 3'b010,
        wr_hold = 3'b100
    } wr_state_t;
endpackage : bus_area_pkg
